// ### shared/acs_pkg.sv
// Package for the conversion sequencer: modes, states, timing and carriers
//
// Contract
// R01 - In multi-sample mode the converter is reset between successive samples.
// R02 - In multi-sample mode the decimator is re-primed before every sample.
// R03 - In multi-sample mode the next sample starts by itself when one ends.
// R04 - Every result is offered for polling, interrupt or DMA collection. The code drops a result that finds the FIFO full and sets OVERRUN.
// R05 - Turbo mode at 8 to 16 bits behaves exactly like multi-sample mode.
// R06 - Turbo mode at 17 to 20 bits resets the converter once per conversion.
// R07 - A conversion begins when the start input is asserted.
// R08 - Continuous mode works with the start input left unconnected.
// R09 - The done output goes high at the completion of every conversion.
// R10 - Outside logic may use the done output as interrupt or DMA request.
// R11 - Continuous mode converts back to back without reset or re-prime.
package acs_pkg;

  typedef enum logic [1:0] {
    ACS_MODE_SINGLE = 2'h0,
    ACS_MODE_CONT   = 2'h1,
    ACS_MODE_MULTI  = 2'h2,
    ACS_MODE_TURBO  = 2'h3
  } acs_mode_type;

  typedef enum logic [4:0] {
    ACS_ST_IDLE  = 5'h01,
    ACS_ST_RESET = 5'h02,
    ACS_ST_PRIME = 5'h04,
    ACS_ST_CONV  = 5'h08,
    ACS_ST_DONE  = 5'h10
  } acs_state_type;

  localparam int          ACS_DATA_W      = 20;
  localparam int          ACS_CNT_W       = 16;
  localparam logic [4:0]  ACS_TURBO_MIN   = 5'h11;
  localparam logic [4:0]  ACS_RES_RST     = 5'h10;
  localparam logic [15:0] ACS_RESET_CYC   = 16'h0004;
  localparam logic [15:0] ACS_PRIME_CYC   = 16'h0008;
  localparam int          ACS_SYNC_STAGES = 3;

  typedef struct packed {
    logic [ACS_DATA_W-1:0] data;
    logic                  first;
  } acs_result_type;

endpackage

// ### rtl/acs_fifo.sv
// Result FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module acs_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
  logic             push, pop;

  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_comb begin
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // Storage has no reset; only pointers define contents
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ### rtl/acs_sequencer.sv
// Delta-sigma conversion sequencer with result FIFO
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  NRST,
  // Configuration
  input  wire acs_mode_type          MODE,
  input  wire logic [4:0]            RESOLUTION,
  input  wire logic                  ENABLE,
  input  wire logic [ACS_CNT_W-1:0]  CONV_CYCLES,
  // Start-of-conversion pin
  input  wire logic                  SOC,
  // Modulator and decimator controls
  output logic                       MOD_RESET,
  output logic                       DEC_PRIME,
  input  wire logic [ACS_DATA_W-1:0] DEC_DATA,
  // Conversion done
  output logic                       EOC,
  // Result stream
  output acs_result_type             RESULT,
  output logic                       RESULT_VALID,
  input  wire logic                  RESULT_READY,
  output logic                       OVERRUN
);
  acs_state_type          st_q, st_d;
  logic [ACS_CNT_W-1:0]   cnt_q, cnt_d;
  logic [2:0]             soc_q;
  logic                   soc_lvl_q, soc_lvl_d, soc_rise;
  logic                   mrst_q, mrst_d, prime_q, prime_d, eoc_q, eoc_d;
  logic                   first_q, first_d, ovr_q, ovr_d;
  logic                   push, fifo_ready, hi_res, skip_prime;
  acs_result_type         fifo_in, fifo_out;
  logic                   fifo_valid, out_take;
  logic                   res_valid_q, res_valid_d;
  acs_result_type         res_q, res_d;

  // Three-stage pin synchroniser; stage 0 feeds only stage 1
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      soc_q <= '0;
    end else begin
      soc_q <= {soc_q[1:0], SOC};
    end
  end

  always_comb begin
    soc_lvl_d = soc_lvl_q;
    if (soc_q[1] == soc_q[2]) begin
      soc_lvl_d = soc_q[2];
    end
  end
  assign soc_rise = soc_lvl_d && !soc_lvl_q;
  assign hi_res   = RESOLUTION >= ACS_TURBO_MIN;
  // Only a fresh start primes in high-resolution turbo
  assign skip_prime = MODE == ACS_MODE_TURBO && hi_res && !first_q;

  // Next state of the sequencer
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    mrst_d  = 1'b0;
    prime_d = 1'b0;
    eoc_d   = 1'b0;
    first_d = first_q;
    ovr_d   = ovr_q;
    push    = 1'b0;
    case (st_q)
      ACS_ST_IDLE: begin
        first_d = 1'b1;
        // R07 start on trigger
        if (ENABLE && MODE == ACS_MODE_SINGLE && soc_rise) begin
          st_d = ACS_ST_RESET;
          cnt_d = ACS_RESET_CYC;
          mrst_d = 1'b1;
        // R08 free running start
        end else if (ENABLE && MODE != ACS_MODE_SINGLE) begin
          st_d = ACS_ST_RESET;
          cnt_d = ACS_RESET_CYC;
          mrst_d = 1'b1;
        end
      end
      ACS_ST_RESET: begin
        mrst_d = 1'b1;
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == 16'h0001) begin
          mrst_d = 1'b0;
          // R06 turbo high resolution skips re-prime
          if (skip_prime) begin
            st_d = ACS_ST_CONV;
            cnt_d = CONV_CYCLES;
          // R02 re-prime after reset
          end else begin
            prime_d = 1'b1;
            st_d = ACS_ST_PRIME;
            cnt_d = ACS_PRIME_CYC;
          end
        end
      end
      ACS_ST_PRIME: begin
        prime_d = 1'b1;
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == 16'h0001) begin
          prime_d = 1'b0;
          st_d = ACS_ST_CONV;
          cnt_d = CONV_CYCLES;
        end
      end
      ACS_ST_CONV: begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q <= 16'h0001) begin
          st_d = ACS_ST_DONE;
          // R09 done pulse
          eoc_d = 1'b1;
          // R04 result offered
          push = 1'b1;
          if (!fifo_ready) begin
            ovr_d = 1'b1;
          end
        end
      end
      ACS_ST_DONE: begin
        first_d = 1'b0;
        if (!ENABLE || MODE == ACS_MODE_SINGLE) begin
          st_d = ACS_ST_IDLE;
        // R11 continuous without reset
        end else if (MODE == ACS_MODE_CONT) begin
          st_d = ACS_ST_CONV;
          cnt_d = CONV_CYCLES;
        // R06 turbo high resolution, reset once per conversion only
        end else if (MODE == ACS_MODE_TURBO && hi_res) begin
          st_d = ACS_ST_RESET;
          cnt_d = ACS_RESET_CYC;
          mrst_d = 1'b1;
        // R01 R03 R05 reset then start next sample
        end else begin
          st_d = ACS_ST_RESET;
          cnt_d = ACS_RESET_CYC;
          mrst_d = 1'b1;
        end
      end
      default: begin
        st_d = ACS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_q      <= ACS_ST_IDLE;
      cnt_q     <= '0;
      soc_lvl_q <= 1'b0;
      mrst_q    <= 1'b0;
      prime_q   <= 1'b0;
      eoc_q     <= 1'b0;
      first_q   <= 1'b1;
      ovr_q     <= 1'b0;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      soc_lvl_q <= soc_lvl_d;
      mrst_q    <= mrst_d;
      prime_q   <= prime_d;
      eoc_q     <= eoc_d;
      first_q   <= first_d;
      ovr_q     <= ovr_d;
    end
  end

  assign fifo_in = '{data: DEC_DATA, first: first_q};

  acs_fifo #(
    .WIDTH ($bits(acs_result_type)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .nrst      (NRST),
    .in_data   (fifo_in),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (out_take)
  );

  // Output stage keeps the stream port registered; it adds one word of depth
  always_comb begin
    out_take    = !res_valid_q || RESULT_READY;
    res_valid_d = res_valid_q;
    res_d       = res_q;
    if (fifo_valid && out_take) begin
      res_valid_d = 1'b1;
      res_d       = fifo_out;
    end else if (RESULT_READY) begin
      res_valid_d = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      res_q       <= '0;
      res_valid_q <= 1'b0;
    end else begin
      res_q       <= res_d;
      res_valid_q <= res_valid_d;
    end
  end

  assign RESULT       = res_q;
  assign RESULT_VALID = res_valid_q;
  assign MOD_RESET    = mrst_q;
  assign DEC_PRIME    = prime_q;
  assign EOC          = eoc_q;
  assign OVERRUN      = ovr_q;

  // R02 prime follows every reset unless skip_prime is set
  sequence reset_end_s;
    mrst_q ##1 !mrst_q;
  endsequence
  prime_after_rst_a: assert property (@(posedge CLK) // R02
    disable iff (!NRST)
    reset_end_s |-> prime_q == !skip_prime)
    else $error("decimator not primed after reset");

  // R06 high-resolution turbo converts right after each reset that follows a done
  turbo_skip_a: assert property (@(posedge CLK) // R06
    disable iff (!NRST)
    (reset_end_s ##0 skip_prime) |-> st_q == ACS_ST_CONV)
    else $error("turbo conversion did not follow its reset");

  // R01 multi mode resets after done
  multi_reset_a: assert property (@(posedge CLK) // R01
    disable iff (!NRST)
    (st_q == ACS_ST_DONE && ENABLE && MODE == ACS_MODE_MULTI)
    |=> mrst_q)
    else $error("no converter reset between samples");

  // R11 continuous skips reset
  cont_no_reset_a: assert property (@(posedge CLK) // R11
    disable iff (!NRST)
    (st_q == ACS_ST_DONE && ENABLE && MODE == ACS_MODE_CONT)
    |=> !mrst_q && !prime_q && st_q == ACS_ST_CONV)
    else $error("continuous mode reset the converter");

  // R09 done pulse is one cycle
  eoc_pulse_a: assert property (@(posedge CLK) // R09
    disable iff (!NRST)
    eoc_q |=> !eoc_q)
    else $error("done output longer than one cycle");

  // R04 done comes with a push
  eoc_push_a: assert property (@(posedge CLK) // R04
    disable iff (!NRST)
    $rose(eoc_q) |-> $past(push))
    else $error("done without stored result");

  // R07 trigger starts conversion
  soc_start_a: assert property (@(posedge CLK) // R07
    disable iff (!NRST)
    (st_q == ACS_ST_IDLE && ENABLE && MODE == ACS_MODE_SINGLE && soc_rise)
    |=> mrst_q)
    else $error("start trigger ignored");

  // R03 next sample automatic
  auto_next_a: assert property (@(posedge CLK) // R03
    disable iff (!NRST)
    (st_q == ACS_ST_DONE && ENABLE &&
     (MODE == ACS_MODE_MULTI || MODE == ACS_MODE_TURBO))
    |=> st_q == ACS_ST_RESET)
    else $error("next sample not started");

  // R05 turbo low resolution resets too
  turbo_low_a: assert property (@(posedge CLK) // R05
    disable iff (!NRST)
    (st_q == ACS_ST_DONE && ENABLE && MODE == ACS_MODE_TURBO && !hi_res)
    |=> mrst_q)
    else $error("turbo low resolution differs from multi");
endmodule
`default_nettype wire

// ### sim/acs_partner_model.sv
// Consumer model: pops results and takes done pulses as requests
`timescale 1ns/1ps
`default_nettype none
module acs_partner_model
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           nrst,
  // Consumer side
  input  wire logic           stall,
  input  wire acs_result_type result,
  input  wire logic           result_valid,
  output logic                result_ready,
  input  wire logic           eoc,
  // Observations
  output int                  pops,
  output acs_result_type      last,
  output int                  irqs
);
  // Ready moves on the falling edge so pops never race the design
  always @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      result_ready <= 1'b0;
    end else begin
      result_ready <= !stall;
    end
  end
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pops <= 0;
      last <= '0;
    end else if (result_valid && result_ready) begin
      pops <= pops + 1;
      last <= result;
    end
  end
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqs <= 0;
    end else if (eoc) begin
      irqs <= irqs + 1;
    end
  end
endmodule
`default_nettype wire

// ### sim/acs_testbench.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench
  import acs_pkg::*;
;
  localparam int fifo_words = 16;
  logic clk = 0, nrst = 0, enable = 0, soc = 0, stall = 0;
  logic mod_reset, dec_prime, eoc, rvalid, rready, overrun;
  acs_mode_type mode = ACS_MODE_SINGLE;
  logic [4:0] res = 5'h10;
  logic [ACS_CNT_W-1:0] conv = 16'h0014;
  logic [ACS_DATA_W-1:0] data = 20'h5a5a5;
  acs_result_type result, last;
  int pops, irqs, errors = 0, checks_done = 0, mr_n = 0, dp_n = 0, eoc_n = 0;

  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (mod_reset === 1'b1) mr_n++;
    if (dec_prime === 1'b1) dp_n++;
    if (eoc === 1'b1) eoc_n++;
  end

  acs_sequencer #(.DEPTH(fifo_words)) acs_sequencer_inst (
    .CLK(clk), .NRST(nrst), .MODE(mode), .RESOLUTION(res),
    .ENABLE(enable), .CONV_CYCLES(conv), .SOC(soc),
    .MOD_RESET(mod_reset), .DEC_PRIME(dec_prime), .DEC_DATA(data),
    .EOC(eoc), .RESULT(result), .RESULT_VALID(rvalid),
    .RESULT_READY(rready), .OVERRUN(overrun));
  acs_partner_model acs_partner_model_inst (
    .clk(clk), .nrst(nrst), .stall(stall), .result(result),
    .result_valid(rvalid), .result_ready(rready), .eoc(eoc),
    .pops(pops), .last(last), .irqs(irqs));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_eoc(input int n);
    int k;
    k = 0;
    while (eoc_n < n && k < 2000) begin
      @(negedge clk);
      k++;
    end
  endtask

  // Counts reset and prime cycles over three samples after the first
  task automatic measure(input acs_mode_type m, input logic [4:0] r,
                         output int mr, output int dp);
    int b, mr0, dp0;
    @(negedge clk);
    mode = m;
    res = r;
    enable = 1'b1;
    b = eoc_n;
    wait_eoc(b + 1);
    mr0 = mr_n;
    dp0 = dp_n;
    wait_eoc(b + 4);
    mr = mr_n - mr0;
    dp = dp_n - dp0;
    check(eoc_n >= b + 4, 1'b1);
    enable = 1'b0;
    repeat (60) @(negedge clk);
  endtask

  task automatic t_single();
    int b, p;
    b = eoc_n;
    p = pops;
    mode = ACS_MODE_SINGLE;
    enable = 1'b1;
    repeat (3) @(negedge clk);
    soc = 1'b1;
    wait_eoc(b + 1);
    repeat (3) @(negedge clk);
    check(mr_n, 4);
    check(dp_n, 8);
    check(pops - p, 1);
    check(last.data, data);
    check(last.first, 1'b1);
    repeat (100) @(negedge clk);
    check(eoc_n - b, 1);
    soc = 1'b0;
    enable = 1'b0;
  endtask

  task automatic t_multi();
    int mr, dp;
    measure(ACS_MODE_MULTI, 5'h10, mr, dp);
    check(mr, 12);
    check(dp, 24);
  endtask

  task automatic t_cont();
    int mr, dp;
    measure(ACS_MODE_CONT, 5'h10, mr, dp);
    check(mr + dp, 0);
  endtask

  task automatic t_turbo();
    logic [4:0] r [4] = '{5'h08, 5'h10, 5'h11, 5'h14};
    int i, mr, dp;
    for (i = 0; i < 4; i++) begin
      measure(ACS_MODE_TURBO, r[i], mr, dp);
      check(mr, 12);
      if (i < 2) begin
        check(dp, 24);
      end else begin
        check(dp, 0);
      end
    end
  endtask

  // Stalled consumer fills the buffer until results are dropped
  task automatic t_fifo();
    int p;
    check(overrun, 1'b0);
    stall = 1'b1;
    mode = ACS_MODE_CONT;
    enable = 1'b1;
    wait_eoc(eoc_n + 18);
    enable = 1'b0;
    repeat (60) @(negedge clk);
    check({rvalid, overrun}, 2'h3);
    p = pops;
    stall = 1'b0;
    repeat (40) @(negedge clk);
    // One word more than the buffer: the output stage holds one
    check(pops - p, fifo_words + 1);
    check(rvalid, 1'b0);
    check(last.first, 1'b0);
    check(irqs, eoc_n);
  endtask

  task automatic give_verdict();
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end

  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    t_single();
    t_multi();
    t_cont();
    t_turbo();
    t_fifo();
    give_verdict();
  end
endmodule
`default_nettype wire
